// >>> cfs_pkg.sv
package cfs_pkg;
    // Program counter, stack, instruction, data and file address widths
    localparam int PC_W       = 10;
    localparam int STACK_W    = 12;
    localparam int INSN_W     = 12;
    localparam int DATA_W     = 8;
    localparam int FADDR_W    = 5;
    // Reset vector: last word of last page
    localparam logic [9:0] PC_RESET_VEC = 10'h3FF;
    // Status register page select bit position
    localparam int STATUS_PAGE_BIT = 5;
    // Counter low latch file address
    localparam logic [4:0] ADDR_COUNTER_LOW = 5'h02;
    localparam logic [4:0] ADDR_STATUS      = 5'h03;
    localparam logic [7:0] STATUS_RESET     = 8'h18;
    // Phase encoding
    typedef enum logic [1:0] {
        CFS_PH_ONE   = 2'b00,
        CFS_PH_TWO   = 2'b01,
        CFS_PH_THREE = 2'b10,
        CFS_PH_FOUR  = 2'b11
    } cfs_phase_e;
    // Opcode classes
    typedef enum logic [2:0] {
        CFS_OP_OTHER = 3'b000,
        CFS_OP_JUMP  = 3'b001,
        CFS_OP_CALL  = 3'b010,
        CFS_OP_RET   = 3'b011,
        CFS_OP_WRLOW = 3'b100,
        CFS_OP_LIT   = 3'b101
    } cfs_op_e;
    // Fixed opcode patterns
    localparam logic [2:0] OPC_JUMP_HI = 3'b101;
    localparam logic [3:0] OPC_CALL_HI = 4'b1001;
    localparam logic [3:0] OPC_RET_HI  = 4'b1000;
    localparam logic [3:0] OPC_LIT_HI  = 4'b1100;
    localparam logic [6:0] OPC_MOVWF   = 7'b0000001;
    localparam logic [11:0] NOP_WORD   = 12'h000;
endpackage

// >>> cfs_phase_gen.sv
`timescale 1ns/1ps
`default_nettype none
module cfs_phase_gen (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst,
    // Phase outputs
    output cfs_pkg::cfs_phase_e     phase,
    output logic                    phase_one,
    output logic                    phase_two,
    output logic                    phase_three,
    output logic                    phase_four
);
    // Divide by four, one-hot one-cycle phase enables
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            phase <= cfs_pkg::CFS_PH_FOUR;
        end else begin
            phase <= cfs_pkg::cfs_phase_e'(2'(phase + 2'h1));
        end
    end
    always_comb begin
        phase_one   = (phase == cfs_pkg::CFS_PH_ONE);
        phase_two   = (phase == cfs_pkg::CFS_PH_TWO);
        phase_three = (phase == cfs_pkg::CFS_PH_THREE);
        phase_four  = (phase == cfs_pkg::CFS_PH_FOUR);
    end
endmodule
`default_nettype wire

// >>> cfs_return_stack.sv
`timescale 1ns/1ps
`default_nettype none
module cfs_return_stack (
    // Clock
    input  wire logic                        sys_clk,
    // Operation strobes
    input  wire logic                        push,
    input  wire logic                        pop,
    input  wire logic [cfs_pkg::STACK_W-1:0] push_addr,
    // Stack levels
    output logic      [cfs_pkg::STACK_W-1:0] level_one,
    output logic      [cfs_pkg::STACK_W-1:0] level_two
);
    // No reset on purpose: contents survive any reset
    // No overflow or underflow flag exists
    always_ff @(posedge sys_clk) begin
        if (push) begin
            level_two <= level_one;
            level_one <= push_addr;
        end else if (pop) begin
            level_one <= level_two;
        end
    end
endmodule
`default_nettype wire

// >>> cfs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module cfs_sequencer (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    // Program memory
    output logic      [cfs_pkg::PC_W-1:0]    prog_addr,
    input  wire logic [cfs_pkg::INSN_W-1:0]  prog_data,
    // Data memory
    output logic      [cfs_pkg::FADDR_W-1:0] data_addr,
    output logic                             data_rd,
    input  wire logic [cfs_pkg::DATA_W-1:0]  data_rdata,
    output logic                             data_wr,
    output logic      [cfs_pkg::DATA_W-1:0]  data_wdata,
    // Core state visible to the datapath
    input  wire logic [cfs_pkg::DATA_W-1:0]  alu_result,
    input  wire logic                        alu_dest_file,
    output logic      [cfs_pkg::INSN_W-1:0]  instruction_holding_register,
    output logic      [cfs_pkg::DATA_W-1:0]  work_reg,
    output logic      [cfs_pkg::DATA_W-1:0]  status_reg,
    output logic      [cfs_pkg::DATA_W-1:0]  operand,
    output logic      [cfs_pkg::PC_W-1:0]    pc,
    output logic                             flushing,
    output logic      [1:0]                  phase_out
);
    cfs_pkg::cfs_phase_e phase;
    logic phase_one;
    logic phase_two;
    logic phase_three;
    logic phase_four;
    logic [cfs_pkg::INSN_W-1:0]  fetched;
    cfs_pkg::cfs_op_e            op;
    logic [cfs_pkg::PC_W-1:0]    next_pc;
    logic                        load_pc;
    logic                        stack_push;
    logic                        stack_pop;
    logic [cfs_pkg::STACK_W-1:0] stack_one;
    logic [cfs_pkg::STACK_W-1:0] stack_two;
    logic [cfs_pkg::STACK_W-1:0] push_value;

    cfs_phase_gen u_phase (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .phase       (phase),
        .phase_one   (phase_one),
        .phase_two   (phase_two),
        .phase_three (phase_three),
        .phase_four  (phase_four)
    );

    cfs_return_stack u_stack (
        .sys_clk   (sys_clk),
        .push      (stack_push),
        .pop       (stack_pop),
        .push_addr (push_value),
        .level_one (stack_one),
        .level_two (stack_two)
    );

    // Classify the executing word
    function automatic cfs_pkg::cfs_op_e classify(
        input logic [cfs_pkg::INSN_W-1:0] w
    );
        if (w[11:9] == cfs_pkg::OPC_JUMP_HI) begin
            classify = cfs_pkg::CFS_OP_JUMP;
        end else if (w[11:8] == cfs_pkg::OPC_CALL_HI) begin
            classify = cfs_pkg::CFS_OP_CALL;
        end else if (w[11:8] == cfs_pkg::OPC_RET_HI) begin
            classify = cfs_pkg::CFS_OP_RET;
        end else if (w[11:8] == cfs_pkg::OPC_LIT_HI) begin
            classify = cfs_pkg::CFS_OP_LIT;
        end else if (w[4:0] == cfs_pkg::ADDR_COUNTER_LOW
                     && w[11:5] == cfs_pkg::OPC_MOVWF) begin
            classify = cfs_pkg::CFS_OP_WRLOW;
        end else begin
            classify = cfs_pkg::CFS_OP_OTHER;
        end
    endfunction

    always_comb begin
        op = classify(instruction_holding_register);
    end

    // Branch load at the phase-one edge that ends the execute cycle,
    // so the counter only ever moves on phase one
    always_comb begin
        next_pc    = pc;
        load_pc    = 1'b0;
        stack_push = 1'b0;
        stack_pop  = 1'b0;
        push_value = {{(cfs_pkg::STACK_W-cfs_pkg::PC_W){1'b0}}, pc};
        if (phase_one && !flushing) begin
            case (op)
                cfs_pkg::CFS_OP_JUMP: begin
                    next_pc = {status_reg[cfs_pkg::STATUS_PAGE_BIT],
                               instruction_holding_register[8:0]};
                    load_pc = 1'b1;
                end
                cfs_pkg::CFS_OP_CALL: begin
                    next_pc = {status_reg[cfs_pkg::STATUS_PAGE_BIT], 1'b0,
                               instruction_holding_register[7:0]};
                    load_pc    = 1'b1;
                    stack_push = 1'b1;
                end
                cfs_pkg::CFS_OP_WRLOW: begin
                    next_pc = {status_reg[cfs_pkg::STATUS_PAGE_BIT], 1'b0,
                               alu_result};
                    load_pc = 1'b1;
                end
                cfs_pkg::CFS_OP_RET: begin
                    next_pc   = stack_one[cfs_pkg::PC_W-1:0];
                    load_pc   = 1'b1;
                    stack_pop = 1'b1;
                end
                default: begin
                    next_pc = pc;
                end
            endcase
        end
    end

    // Program counter: reset to last word, wraps naturally to zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pc <= cfs_pkg::PC_RESET_VEC;
        end else if (load_pc) begin
            pc <= next_pc;
        end else if (phase_one) begin
            pc <= 10'(pc + 10'h001);
        end
    end

    // Fetch address presented from the counter
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prog_addr <= cfs_pkg::PC_RESET_VEC;
        end else if (phase_two) begin
            prog_addr <= pc;
        end
    end

    // Fetch word captured at phase four, executed next cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fetched <= cfs_pkg::NOP_WORD;
        end else if (phase_four) begin
            fetched <= prog_data;
        end
    end

    // Branch discards the prefetched word
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            instruction_holding_register <= cfs_pkg::NOP_WORD;
            flushing                     <= 1'b0;
        end else if (phase_one) begin
            instruction_holding_register <= fetched;
            flushing                     <= load_pc;
        end
    end

    // Data memory operand read and result write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            data_addr <= '0;
            data_rd   <= 1'b0;
        end else begin
            if (phase_one) begin
                data_addr <= fetched[4:0];
            end
            data_rd <= phase_one && !load_pc;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            operand <= '0;
        end else if (phase_two && !flushing) begin
            operand <= data_rdata;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            data_wr    <= 1'b0;
            data_wdata <= '0;
        end else begin
            data_wr    <= phase_three && !flushing && alu_dest_file
                          && op != cfs_pkg::CFS_OP_JUMP
                          && op != cfs_pkg::CFS_OP_CALL
                          && op != cfs_pkg::CFS_OP_RET
                          && op != cfs_pkg::CFS_OP_LIT;
            data_wdata <= alu_result;
        end
    end

    // Working register literal loads
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            work_reg <= '0;
        end else if (phase_four && !flushing
                     && (op == cfs_pkg::CFS_OP_RET
                         || op == cfs_pkg::CFS_OP_LIT)) begin
            work_reg <= instruction_holding_register[7:0];
        end
    end

    // Status: page bits cleared by reset, written via data path
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            status_reg <= cfs_pkg::STATUS_RESET;
        end else if (phase_four && !flushing && alu_dest_file
                     && op == cfs_pkg::CFS_OP_OTHER
                     && instruction_holding_register[4:0]
                        == cfs_pkg::ADDR_STATUS) begin
            status_reg <= alu_result;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            phase_out <= 2'h2;
        end else begin
            phase_out <= phase;
        end
    end

    // Stack overflow is silent: no flag is produced
    // Stack sized by its package width
endmodule
`default_nettype wire

// >>> cfs_seq_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cfs_seq_chk (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // Observed outputs
    input wire logic        data_rd,
    input wire logic        data_wr,
    input wire logic [11:0] instruction_holding_register,
    input wire logic [7:0]  work_reg,
    input wire logic [7:0]  status_reg,
    input wire logic [9:0]  pc,
    input wire logic        flushing,
    input wire logic [1:0]  phase_out
);
    // Word that retired at the last phase-one edge
    logic [11:0] ir;
    logic [7:0]  w;
    logic        pg;
    logic        fl;
    always_ff @(posedge sys_clk) begin
        ir <= instruction_holding_register;
        w <= work_reg;
        pg <= status_reg[5];
        fl <= flushing;
    end
    wire nb = phase_out == 2'h0 && !fl;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_pulse(s);
        s ##1 !s;
    endsequence
    sequence s_flush;
        flushing [*4] ##1 !flushing;
    endsequence
    property p_phase;
        1 |=> phase_out == $past(phase_out) + 2'h1;
    endproperty
    property p_hold;
        phase_out != 2'h0 |-> $stable(pc);
    endproperty
    property p_inc;
        phase_out == 2'h0 && (fl || (ir[11:10] != 2'b10 && ir != 12'h022))
            |-> pc == $past(pc) + 10'h001;
    endproperty
    property p_jump;
        nb && ir[11:9] == 3'b101 |-> flushing && pc == {pg, ir[8:0]};
    endproperty
    property p_call;
        nb && ir[11:8] == 4'h9 |-> flushing && pc == {pg, 1'b0, ir[7:0]};
    endproperty
    property p_low;
        nb && ir == 12'h022 |-> flushing && pc == {pg, 1'b0, w};
    endproperty
    property p_ret;
        nb && ir[11:8] == 4'h8 |-> flushing && work_reg == ir[7:0];
    endproperty
    property p_rd;
        data_rd |-> phase_out == 2'h0 ##0 s_pulse(data_rd);
    endproperty
    property p_wr;
        data_wr |-> phase_out == 2'h2 ##0 s_pulse(data_wr);
    endproperty
    property p_flush;
        $rose(flushing) |-> s_flush;
    endproperty
    property p_boot;
        $fell(rst) |-> pc == 10'h3FF ##2 pc == 10'h000 && !status_reg[5];
    endproperty
    a_phase: assert property (p_phase)
        else $error("phase order broken");
    a_hold: assert property (p_hold)
        else $error("counter moved off phase one");
    a_inc: assert property (p_inc)
        else $error("counter did not step by one");
    a_jump: assert property (p_jump)
        else $error("jump target wrong");
    a_call: assert property (p_call)
        else $error("call target wrong");
    a_low: assert property (p_low)
        else $error("low latch write target wrong");
    a_ret: assert property (p_ret)
        else $error("return literal not loaded");
    a_rd: assert property (p_rd)
        else $error("read strobe off phase two");
    a_wr: assert property (p_wr)
        else $error("write strobe off phase four");
    a_flush: assert property (p_flush)
        else $error("discard not one cycle");
    a_boot: assert property (p_boot)
        else $error("reset vector did not wrap");
endmodule
bind cfs_sequencer cfs_seq_chk u_chk (.sys_clk, .rst, .data_rd, .data_wr,
    .instruction_holding_register, .work_reg, .status_reg, .pc, .flushing,
    .phase_out);
`default_nettype wire

// >>> cfs_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfs_mem_model (
    // Clock
    input  wire logic        sys_clk,
    // Program memory
    input  wire logic [9:0]  prog_addr,
    output logic      [11:0] prog_data,
    // Data memory
    input  wire logic [4:0]  data_addr,
    input  wire logic        data_rd,
    output logic      [7:0]  data_rdata,
    input  wire logic        data_wr,
    input  wire logic [7:0]  data_wdata
);
    logic [11:0] rom [1024];
    logic [7:0]  ram [32];
    initial begin
        foreach (rom[i]) rom[i] = 12'h000;
        foreach (ram[i]) ram[i] = 8'hA5;
    end
    assign prog_data = rom[prog_addr];
    // Inverted when not read, so a stale byte cannot pass as good
    assign data_rdata = data_rd ? ram[data_addr] : ~ram[data_addr];
    always @(posedge sys_clk) begin
        if (data_wr) begin
            ram[data_addr] <= data_wdata;
        end
    end
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    wire  [7:0]  alu_result;
    logic        alu_dest_file = 1'b1;
    wire  [9:0]  prog_addr, pc;
    wire  [11:0] prog_data, ir;
    wire  [4:0]  data_addr;
    wire  [7:0]  data_rdata, data_wdata, work_reg, status_reg, operand;
    wire         data_rd, data_wr, flushing;
    wire  [1:0]  phase_out;
    int          error_cnt = 0;
    int          tests_run = 0;

    // Datapath stand-in: every result is the working register
    assign alu_result = work_reg;

    always #10 sys_clk = ~sys_clk;

    cfs_sequencer dut (.sys_clk, .rst, .prog_addr, .prog_data, .data_addr,
        .data_rd, .data_rdata, .data_wr, .data_wdata, .alu_result,
        .alu_dest_file, .instruction_holding_register(ir), .work_reg,
        .status_reg, .operand, .pc, .flushing, .phase_out);
    cfs_mem_model mem (.sys_clk, .prog_addr, .prog_data, .data_addr,
        .data_rd, .data_rdata, .data_wr, .data_wdata);

    task automatic check(input string name, input logic [11:0] seen,
                         input logic [11:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Bounded wait for the counter to reach a target
    task automatic wait_pc(input logic [9:0] target);
        int n;
        for (n = 0; n < 100 && pc !== target; n++) begin
            @(negedge sys_clk);
        end
        check("pc", {2'h0, pc}, {2'h0, target});
        if (n == 100) close_out();
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (5) @(negedge sys_clk);
        check("pc_in_reset", {2'h0, pc}, 12'h3FF);
        rst = 1'b0;
        repeat (2) @(negedge sys_clk);
        check("pc_wrap", {2'h0, pc}, 12'h000);
        check("status", {4'h0, status_reg}, 12'h018);
        check("phase", {10'h0, phase_out}, 12'h000);
    endtask

    // Low latch write, jump, nested calls and extra returns
    task automatic t_program();
        do_reset();
        wait_pc(10'h010);
        check("work", {4'h0, work_reg}, 12'h010);
        check("ram", {4'h0, mem.ram[10]}, 12'h010);
        check("operand", {4'h0, operand}, 12'h0A5);
        wait_pc(10'h1FF);
        wait_pc(10'h006);
        wait_pc(10'h008);
        wait_pc(10'h007);
        check("work", {4'h0, work_reg}, 12'h007);
        wait_pc(10'h200);
        check("work", {4'h0, work_reg}, 12'h0AA);
        repeat (8) @(negedge sys_clk);
        check("pc_repeat", {2'h0, pc}, 12'h200);
        check("work", {4'h0, work_reg}, 12'h0BB);
    endtask

    // Second reset mid-run: a return still finds the old level one
    task automatic t_reset_keeps_stack();
        mem.rom[0] = 12'h8CC;
        do_reset();
        wait_pc(10'h200);
        check("work", {4'h0, work_reg}, 12'h0CC);
    endtask

    initial begin
        @(negedge sys_clk);
        mem.rom[10'h000] = 12'hC10;
        mem.rom[10'h001] = 12'h02A;
        mem.rom[10'h002] = 12'h20A;
        mem.rom[10'h003] = 12'h022;
        mem.rom[10'h010] = 12'hBFF;
        mem.rom[10'h1FF] = 12'h906;
        mem.rom[10'h006] = 12'h908;
        mem.rom[10'h008] = 12'h807;
        mem.rom[10'h007] = 12'h8AA;
        mem.rom[10'h200] = 12'h8BB;
        t_program();
        t_reset_keeps_stack();
        close_out();
    end
endmodule
`default_nettype wire
